// *** hw/srwd_defines.vh ***
// Purpose: constants of the system runtime watchdog
// Assumes: 125 MHz clock, classic Wishbone with 32-bit data
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef SRWD_DEFINES_VH
`define SRWD_DEFINES_VH

// Clock and timing
`define SRWD_CLK_MHZ 125
`define SRWD_TICK_US 1000
`define SRWD_TICK_CYC (`SRWD_TICK_US * `SRWD_CLK_MHZ)
`define SRWD_RST_PULSE_NS 1000
`define SRWD_RST_CYC ((`SRWD_RST_PULSE_NS * `SRWD_CLK_MHZ + 999) / 1000)

// Register byte offsets
`define SRWD_REG_CTRL 8'h00
`define SRWD_REG_SERVICE 8'h04
`define SRWD_REG_STATUS 8'h08
`define SRWD_REG_EVENT 8'h0c
`define SRWD_REG_MASK 8'h10
`define SRWD_REG_COUNT 8'h14

// Control fields and reset value
`define SRWD_CTRL_EN 0
`define SRWD_CTRL_MACRO 1
`define SRWD_CTRL_TSEL_LO 2
`define SRWD_CTRL_TSEL_HI 4
`define SRWD_CTRL_REACT_LO 5
`define SRWD_CTRL_REACT_HI 6
`define SRWD_CTRL_RESET 7'h00

// Reaction codes
`define SRWD_REACT_RESET 2'h0
`define SRWD_REACT_NONE 2'h1
`define SRWD_REACT_RESTART 2'h2
`define SRWD_REACT_SHUTDOWN 2'h3

// Status and event bits
`define SRWD_ST_ALARM 0
`define SRWD_ST_RUN 1
`define SRWD_EV_EXPIRE 0
`define SRWD_EV_RESTART 1
`define SRWD_EV_SHUTDOWN 2
`define SRWD_EV_HWRESET 3
`define SRWD_EV_W 4

// Monitoring periods in milliseconds
`define SRWD_NRM_T0 16'h005e
`define SRWD_NRM_T1 16'h00d2
`define SRWD_NRM_T2 16'h0154
`define SRWD_NRM_T3 16'h01cc
`define SRWD_NRM_T4 16'h024e
`define SRWD_NRM_T5 16'h02c6
`define SRWD_NRM_T6 16'h0348
`define SRWD_NRM_T7 16'h03c0
`define SRWD_MAC_T0 16'h07d0
`define SRWD_MAC_T1 16'h0fa0
`define SRWD_MAC_T2 16'h1770
`define SRWD_MAC_T3 16'h1f40
`define SRWD_MAC_T4 16'h3e80
`define SRWD_MAC_T5 16'h7d00
`define SRWD_MAC_T6 16'hbb80
`define SRWD_MAC_T7 16'hfa00

`endif

// *** hw/srwd_period.v ***
// Purpose: maps mode and time select to a period in milliseconds
// Assumes: purely combinational lookup
// Notes: sixteen fixed periods, eight per mode
`timescale 1ns/1ps
`default_nettype none
`include "srwd_defines.vh"
module srwd_period (
    // Selection
    input wire macro_i,
    input wire [2:0] tsel_i,
    // Result
    output reg [15:0] period_ms_o
);
    always @* begin
        case ({macro_i, tsel_i})
            4'h0: period_ms_o = `SRWD_NRM_T0;
            4'h1: period_ms_o = `SRWD_NRM_T1;
            4'h2: period_ms_o = `SRWD_NRM_T2;
            4'h3: period_ms_o = `SRWD_NRM_T3;
            4'h4: period_ms_o = `SRWD_NRM_T4;
            4'h5: period_ms_o = `SRWD_NRM_T5;
            4'h6: period_ms_o = `SRWD_NRM_T6;
            4'h7: period_ms_o = `SRWD_NRM_T7;
            4'h8: period_ms_o = `SRWD_MAC_T0;
            4'h9: period_ms_o = `SRWD_MAC_T1;
            4'ha: period_ms_o = `SRWD_MAC_T2;
            4'hb: period_ms_o = `SRWD_MAC_T3;
            4'hc: period_ms_o = `SRWD_MAC_T4;
            4'hd: period_ms_o = `SRWD_MAC_T5;
            4'he: period_ms_o = `SRWD_MAC_T6;
            default: period_ms_o = `SRWD_MAC_T7;
        endcase
    end
endmodule // srwd_period
`default_nettype wire

// *** hw/srwd_tick.v ***
// Purpose: one-cycle enable pulse every millisecond
// Assumes: single clock, synchronous active-high reset
// Notes: clear restarts the fraction so a service starts a whole period
`timescale 1ns/1ps
`default_nettype none
module srwd_tick #(
    parameter integer TICK_CYCLES = 125000,
    parameter integer CW = 17
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Control
    input wire clear_i,
    // Tick
    output reg tick_o
);
    reg [CW-1:0] cnt_q;

    always @(posedge ref_clk_i) begin
        if (reset_i || clear_i) begin
            cnt_q <= {CW{1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q == TICK_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
            cnt_q <= {CW{1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule // srwd_tick
`default_nettype wire

// *** hw/srwd_top.v ***
// Purpose: system runtime watchdog with a classic Wishbone register slave
// Assumes: one 125 MHz clock; reset_i is the power-on reset only
// Notes: sys_reset_o resets the rest of the system, never this block,
//   so alarm and configuration outlive the restart it causes
//   Register map (byte offsets):
//   0x00 control: [0] enable [1] macro mode [4:2] time select [6:5] reaction
//   0x04 service: any write with lane 0 enabled restarts the count
//   0x08 status: [0] alarm [1] running; write one to bit 0 to acknowledge
//   0x0c events: [0] expiry [1] restart [2] shutdown [3] hardware reset, read clears
//   0x10 event mask, same layout; 0x14 elapsed milliseconds
//   Reactions: 0 hardware reset, 1 none, 2 OS restart, 3 OS shutdown
//
// Contract
// - Reset reaction asserts hardware reset at once
// - No-reset reaction only records the expiry
// - Restart reaction requests OS restart, no reset
// - Shutdown reaction requests OS shutdown, no reset
// - Alarm survives restart, cleared by software acknowledge
// - Configuration survives the watchdog-caused restart
// - Normal mode offers eight periods 94-960 ms
// - Macro mode offers eight periods 2-64 s
`timescale 1ns/1ps
`default_nettype none
`include "srwd_defines.vh"
module srwd_top #(
    parameter integer TICK_CYCLES = `SRWD_TICK_CYC,
    parameter integer RST_CYCLES = `SRWD_RST_CYC
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // System reactions
    output reg sys_reset_o,
    output reg os_restart_o,
    output reg os_shutdown_o,
    output reg alarm_o,
    // Interrupt
    output reg irq_o
);
    // One-hot states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_EXP = 3'b100;

    localparam [7:0] RST_LEN = RST_CYCLES[7:0];

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;
    wire bus_rd = bus_req & ~wb_we_i;
    wire hit_ctrl = (wb_adr_i == `SRWD_REG_CTRL);
    wire hit_svc = (wb_adr_i == `SRWD_REG_SERVICE);
    wire hit_stat = (wb_adr_i == `SRWD_REG_STATUS);
    wire hit_ev = (wb_adr_i == `SRWD_REG_EVENT);
    wire hit_mask = (wb_adr_i == `SRWD_REG_MASK);
    wire hit_cnt = (wb_adr_i == `SRWD_REG_COUNT);

    // Registers
    reg [6:0] ctrl_q;
    reg [6:0] ctrl_d;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [15:0] ms_cnt_q;
    reg [15:0] ms_cnt_d;
    reg [7:0] rst_cnt_q;
    reg [7:0] rst_cnt_d;
    reg alarm_q;
    reg alarm_d;
    reg restart_q;
    reg restart_d;
    reg shutdown_q;
    reg shutdown_d;
    reg [`SRWD_EV_W-1:0] ev_q;
    wire [`SRWD_EV_W-1:0] ev_d;
    reg [`SRWD_EV_W-1:0] mask_q;
    reg [`SRWD_EV_W-1:0] mask_d;
    reg [31:0] rdata_d;

    // Control fields
    wire en = ctrl_q[`SRWD_CTRL_EN];
    wire macro = ctrl_q[`SRWD_CTRL_MACRO];
    wire [2:0] tsel = ctrl_q[`SRWD_CTRL_TSEL_HI:`SRWD_CTRL_TSEL_LO];
    wire [1:0] react = ctrl_q[`SRWD_CTRL_REACT_HI:`SRWD_CTRL_REACT_LO];
    wire running = state_q[1];

    // Reaction decode; the no-reset option drives none of these
    wire react_hw = (react == `SRWD_REACT_RESET);
    wire react_os_rs = (react == `SRWD_REACT_RESTART);
    wire react_os_sd = (react == `SRWD_REACT_SHUTDOWN);

    // Register write strobes; byte lane 0 carries every writable field,
    //   so a write with lane 0 off changes nothing but is still acknowledged
    wire wr_lane0 = bus_wr & wb_sel_i[0];
    wire wr_ctrl = wr_lane0 & hit_ctrl;
    wire wr_svc = wr_lane0 & hit_svc;
    wire wr_stat = wr_lane0 & hit_stat;
    wire wr_mask = wr_lane0 & hit_mask;

    // Read strobe of the event register, which empties it
    wire rd_ev = bus_rd & hit_ev;

    // A service write; the written value carries no meaning
    wire service = wr_svc;

    // Enabling from idle also starts a fresh count
    wire arm = wr_ctrl & wb_dat_i[`SRWD_CTRL_EN] & state_q[0];

    // Alarm acknowledge: write one to the alarm bit of the status register
    wire ack_alarm = wr_stat & wb_dat_i[`SRWD_ST_ALARM];

    wire tick;
    wire [15:0] period_ms;
    wire [15:0] ms_next = ms_cnt_q + 16'h0001;

    // Expiry once the elapsed milliseconds reach the period
    // A shorter period chosen mid-count expires at the next tick
    wire expire = running & tick & (ms_next >= period_ms);

    // Expiry split by reaction
    wire exp_hw = expire & react_hw;
    wire exp_os_rs = expire & react_os_rs;
    wire exp_os_sd = expire & react_os_sd;

    // Millisecond time base, restarted by each service
    // Clearing the fraction makes every period a whole number of ticks
    srwd_tick #(
        .TICK_CYCLES(TICK_CYCLES),
        .CW(17)
    ) u_tick (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(service | arm),
        .tick_o(tick)
    );

    // Period lookup from mode bit and time select
    srwd_period u_period (
        .macro_i(macro),
        .tsel_i(tsel),
        .period_ms_o(period_ms)
    );

    // Control register; only reset_i touches it, not the system reset
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wb_dat_i[6:0];
        end
    end

    // Mask register
    always @* begin
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = wb_dat_i[`SRWD_EV_W-1:0];
        end
    end

    // State machine
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (en) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!en) begin
                    state_d = ST_IDLE;
                end else if (expire) begin
                    state_d = ST_EXP;
                end
            end
            ST_EXP: begin
                // Stays expired until software services it again or clears the enable bit
                if (!en) begin
                    state_d = ST_IDLE;
                end else if (service) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Elapsed time counter
    // Counting stops at expiry and the count clears once the state leaves run
    always @* begin
        ms_cnt_d = ms_cnt_q;
        if (service || arm || !running) begin
            ms_cnt_d = 16'h0000;
        end else if (tick && !expire) begin
            ms_cnt_d = ms_next;
        end
    end

    // Hardware reset pulse; a fixed length keeps it independent of software
    always @* begin
        rst_cnt_d = rst_cnt_q;
        if (exp_hw) begin
            rst_cnt_d = RST_LEN;
        end else if (rst_cnt_q != 8'h00) begin
            rst_cnt_d = rst_cnt_q - 8'h01;
        end
    end

    // Alarm flag: an expiry in the clearing cycle wins
    always @* begin
        alarm_d = alarm_q;
        if (ack_alarm) begin
            alarm_d = 1'b0;
        end
        if (expire) begin
            alarm_d = 1'b1;
        end
    end

    // OS requests stand until the alarm is acknowledged
    always @* begin
        restart_d = restart_q & alarm_d;
        shutdown_d = shutdown_q & alarm_d;
        if (exp_os_rs) begin
            restart_d = 1'b1;
        end
        if (exp_os_sd) begin
            shutdown_d = 1'b1;
        end
    end

    // Sticky events, cleared by reading them; a new event wins over the clear
    wire [`SRWD_EV_W-1:0] ev_set;
    assign ev_set[`SRWD_EV_EXPIRE] = expire;
    assign ev_set[`SRWD_EV_RESTART] = exp_os_rs;
    assign ev_set[`SRWD_EV_SHUTDOWN] = exp_os_sd;
    assign ev_set[`SRWD_EV_HWRESET] = exp_hw;

    genvar gi;
    generate
        for (gi = 0; gi < `SRWD_EV_W; gi = gi + 1) begin : g_ev
            assign ev_d[gi] = ev_set[gi] | (ev_q[gi] & ~rd_ev);
        end
    endgenerate

    // Interrupt level from the next event and mask values, so it follows
    //   a clearing read in the same cycle as the events themselves
    wire irq_d = |(ev_d & mask_d);

    // Reset pulse stands while the counter runs
    wire sys_rst_d = (rst_cnt_d != 8'h00);

    // Read data; unmapped addresses read as zero
    // Zero outside an answer so a stale word never looks valid
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d[6:0] = ctrl_q;
        end else if (hit_stat) begin
            rdata_d[`SRWD_ST_ALARM] = alarm_q;
            rdata_d[`SRWD_ST_RUN] = state_q[1];
        end else if (hit_ev) begin
            rdata_d[`SRWD_EV_W-1:0] = ev_q;
        end else if (hit_mask) begin
            rdata_d[`SRWD_EV_W-1:0] = mask_q;
        end else if (hit_cnt) begin
            rdata_d[15:0] = ms_cnt_q;
        end
    end

    // Register update
    // Only reset_i reaches here; the system reset output never feeds back
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl_q <= `SRWD_CTRL_RESET;
            mask_q <= {`SRWD_EV_W{1'b0}};
            state_q <= ST_IDLE;
            ms_cnt_q <= 16'h0000;
            rst_cnt_q <= 8'h00;
            alarm_q <= 1'b0;
            restart_q <= 1'b0;
            shutdown_q <= 1'b0;
            ev_q <= {`SRWD_EV_W{1'b0}};
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            state_q <= state_d;
            ms_cnt_q <= ms_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            alarm_q <= alarm_d;
            restart_q <= restart_d;
            shutdown_q <= shutdown_d;
            ev_q <= ev_d;
        end
    end

    // Registered outputs
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            sys_reset_o <= 1'b0;
            os_restart_o <= 1'b0;
            os_shutdown_o <= 1'b0;
            alarm_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            // Every request is acknowledged, unmapped ones included
            // The ack is registered, so masking the request with it avoids a second answer
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rdata_d : 32'h0000_0000;
            sys_reset_o <= sys_rst_d;
            os_restart_o <= restart_d;
            os_shutdown_o <= shutdown_d;
            alarm_o <= alarm_d;
            irq_o <= irq_d;
        end
    end

endmodule // srwd_top
`default_nettype wire

// *** test/srwd_host.sv ***
// Purpose: host processor model on the register bus
// Assumes: classic single Wishbone cycles
// Notes: released data lines show the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module srwd_host (
    // Clock and answer
    input wire ref_clk_i,
    input wire wb_ack_i,
    input wire [31:0] wb_dat_i,
    // Request
    output logic wb_cyc_o = 1'b0,
    output logic wb_stb_o = 1'b0,
    output logic wb_we_o = 1'b0,
    output logic [7:0] wb_adr_o = 8'h00,
    output logic [3:0] wb_sel_o = 4'hf,
    output logic [31:0] wb_dat_o = 32'h0
);
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        begin
            wb_cyc_o <= 1'b1;
            wb_stb_o <= 1'b1;
            wb_we_o <= w;
            wb_adr_o <= a;
            wb_dat_o <= d;
            @(posedge ref_clk_i);
            while (wb_ack_i !== 1'b1) @(posedge ref_clk_i);
            q = wb_dat_i;
            wb_cyc_o <= 1'b0;
            wb_stb_o <= 1'b0;
            wb_we_o <= 1'b0;
            wb_dat_o <= ~d;
            @(posedge ref_clk_i);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        begin
            xfer(1'b1, a, d, q);
        end
    endtask
endmodule // srwd_host
`default_nettype wire

// *** test/srwd_props.sv ***
// Purpose: port checks for srwd_top
// Assumes: one clock, sync reset
// Notes: bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module srwd_props #(
    parameter integer RST_CYCLES = 4
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Reactions
    input wire sys_reset_o,
    input wire os_restart_o,
    input wire os_shutdown_o,
    input wire alarm_o,
    input wire irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    logic [7:0] rlen_q;
    wire clr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_dat_i[0] & (wb_adr_i == 8'h08);
    // Length of the current system reset pulse
    always @(posedge ref_clk_i) begin
        if (reset_i || !sys_reset_o)
            rlen_q <= 8'h00;
        else
            rlen_q <= rlen_q + 8'h01;
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    quiet_reset_a: assert property ($fell(reset_i) |->
        !(sys_reset_o | os_restart_o | os_shutdown_o | alarm_o | irq_o | wb_ack_o))
        else $error("output high after reset");
    rst_len_a: assert property ($fell(sys_reset_o) |-> rlen_q == RST_CYCLES)
        else $error("system reset pulse length wrong");
    rst_alarm_a: assert property ($rose(sys_reset_o) |-> alarm_o && !os_restart_o && !os_shutdown_o)
        else $error("system reset without alarm");
    os_alarm_a: assert property (os_restart_o || os_shutdown_o |-> alarm_o && !sys_reset_o)
        else $error("os request without alarm");
    alarm_hold_a: assert property ($fell(alarm_o) |-> $past(clr) || $past(clr, 2))
        else $error("alarm dropped without acknowledge");
endmodule // srwd_props
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench for srwd_top
// Assumes: 1 ms shortened to 10 cycles, reset pulse 4 cycles
// Notes: expiry time is checked within a few cycles of slack
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_i;
    logic reset_i;
    wire cyc, stb, we, ack, sys_rst, os_rs, os_sd, alarm, irq;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] wdat, rdat;
    integer fail_count, check_count, cyc_n;
    srwd_host u_host (.ref_clk_i(ref_clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    srwd_top #(.TICK_CYCLES(10), .RST_CYCLES(4)) u_dut (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sys_reset_o(sys_rst),
        .os_restart_o(os_rs), .os_shutdown_o(os_sd), .alarm_o(alarm), .irq_o(irq));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        begin
            u_host.xfer(1'b0, a, 32'h0, q);
            chk(q, exp);
        end
    endtask
    // Arm, optionally service a few times, then let it expire and clean up
    task expire(input logic [31:0] ctl, input integer p, input logic [1:0] r,
        input logic [31:0] ev, input integer gaps);
        integer n;
        begin
            u_host.wr(8'h00, ctl);
            repeat (gaps) begin
                repeat (p * 10 - 60) @(posedge ref_clk_i);
                u_host.wr(8'h04, 32'h0);
            end
            n = 0;
            while (alarm !== 1'b1) begin
                @(posedge ref_clk_i);
                n = n + 1;
            end
            chk({31'h0, n >= p * 10 - 4 && n <= p * 10 + 4}, 32'h1);
            chk({29'h0, sys_rst, os_rs, os_sd}, {29'h0, r == 2'd0, r == 2'd2, r == 2'd3});
            repeat (8) @(posedge ref_clk_i);
            chk({30'h0, alarm, sys_rst}, 32'h2);
            rd_chk(8'h00, ctl);
            chk({31'h0, irq}, 32'h1);
            u_host.wr(8'h10, 32'h0);
            chk({31'h0, irq}, 32'h0);
            u_host.wr(8'h10, 32'hf);
            u_host.wr(8'h08, 32'h1);
            chk({31'h0, alarm, os_rs | os_sd}, 32'h0);
            rd_chk(8'h0c, ev);
            chk({31'h0, irq}, 32'h0);
            u_host.wr(8'h00, 32'h0);
            $display("test expire ctl %h done", ctl);
        end
    endtask
    task t_regs;
        begin
            rd_chk(8'h00, 32'h0);
            u_host.wr(8'h40, 32'hffff);
            rd_chk(8'h40, 32'h0);
            u_host.wr(8'h10, 32'hf);
            rd_chk(8'h10, 32'hf);
            $display("test regs done");
        end
    endtask
    task t_react;
        integer r;
        begin
            for (r = 0; r < 4; r = r + 1)
                expire({25'h0, r[1:0], 5'h01}, 94, r[1:0], (r == 0) ? 32'h9 : (r == 2) ? 32'h3 :
                    (r == 3) ? 32'h5 : 32'h1, 0);
        end
    endtask
    task t_modes;
        begin
            expire(32'h3d, 960, 2'd1, 32'h1, 2);
            expire(32'h23, 2000, 2'd1, 32'h1, 0);
        end
    endtask
    always @(posedge ref_clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 80000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    initial begin
        fail_count = 0;
        check_count = 0;
        cyc_n = 0;
        reset_i = 1'b1;
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i);
        t_regs;
        t_react;
        t_modes;
        complete_run;
    end
endmodule // tb_top
bind srwd_top srwd_props #(.RST_CYCLES(RST_CYCLES)) u_props (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sys_reset_o(sys_reset_o), .os_restart_o(os_restart_o),
    .os_shutdown_o(os_shutdown_o), .alarm_o(alarm_o), .irq_o(irq_o));
`default_nettype wire
